// >>> hw/fbcl_pkg.sv
`default_nettype none
package fbcl_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SYS_CLK_MAX_MHZ = 133;
  localparam int FLASH_ACC_NS = 90;
  localparam int FLASH_ACC_CYC =
    (FLASH_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_LOW_NS = 300;
  localparam int PROG_LOW_CYC =
    (PROG_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLASH_WE_NS = 50;
  localparam int FLASH_WE_CYC =
    (FLASH_WE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CFG_RATE_MBPS = 152;
  localparam int DONE_EXTRA_CLKS = 8;

  // ==========================================================
  // Geometry
  localparam int NUM_SETS = 8;
  localparam int SET_SEL_W = 3;
  localparam int NUM_CS = 4;
  localparam int CFG_DW = 8;
  localparam int FLASH_DW = 16;
  localparam int FLASH_AW = 22;
  localparam int SET_AW = FLASH_AW - SET_SEL_W;

  // ==========================================================
  // Target mode pin codes, bit 0 drives M0
  localparam logic [2:0] MODE_SERIAL = 3'h7;
  localparam logic [2:0] MODE_PARALLEL = 3'h6;

  // ==========================================================
  // Reset values
  localparam logic [3:0] CS_N_IDLE = 4'hf;
  localparam logic [7:0] CFG_DATA_IDLE = 8'hff;

  typedef enum logic [2:0] {
    CF_IDLE  = 3'h0,
    CF_PROG  = 3'h1,
    CF_INIT  = 3'h2,
    CF_LOAD  = 3'h3,
    CF_FLUSH = 3'h4
  } fbcl_cfg_state_e;

  typedef enum logic [1:0] {
    FL_IDLE  = 2'h0,
    FL_READ  = 2'h1,
    FL_WRITE = 2'h2
  } fbcl_flash_state_e;

  typedef struct packed {
    logic error;
    logic done;
    logic busy;
    logic flash_off;
  } fbcl_status_s;

  typedef struct packed {
    logic [FLASH_AW-1:0] addr;
    logic                ce_n;
    logic                oe_n;
    logic                we_n;
  } fbcl_flash_s;

endpackage : fbcl_pkg
`default_nettype wire

// >>> hw/fbcl_loader.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Enable low releases all flash control outputs
// - Reset pulse: reset targets, sample select, load
// - Eight design sets, reload any at any time
// - Set chosen by select pins or scan port
// - Configuration clock at most half system clock
// - After power-up read flash and configure targets
// - Aggregate data rate reaches 111 Mb per second: one 16-bit word per 18 clocks of 8 ns
// - Parallel mode: output bit n is bus Dn
// - Serial mode: output n feeds chain n
// - Read/write output drives parallel bus direction
// - Chip select for parallel target zero
// - Chip selects for parallel targets one to three
// - Three mode outputs set target M0 to M2
// - Program output resets target configuration
// - Init input monitored during configuration
// - Parallel mode holds data while busy high
// - Done input marks configuration complete
// - Four status outputs show configuration progress
// - Read flash and allow in-system flash writes
module fbcl_loader
  import fbcl_pkg::*;
#(
  parameter int CFG_CLK_HALF = 1,
  parameter int SET_WORDS = 65536
)(
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                clk_en,
  input  wire logic                flash_ctrl_enable,
  input  wire logic                sys_reset_pulse,
  input  wire logic [2:0]          design_set_select,
  input  wire logic                jtag_set_override,
  input  wire logic [2:0]          jtag_set_value,
  input  wire logic                parallel_mode,
  input  wire logic [3:0]          target_cs_enable,
  output var  fbcl_status_s        status,
  output var  logic [2:0]          cfg_mode,
  output var  logic                target_program_out_n,
  output var  logic                cfg_clock_pin,
  output var  logic [7:0]          cfg_data,
  output var  logic                read_write_n,
  output var  logic [3:0]          cfg_cs_n,
  input  wire logic                cfg_init_in,
  input  wire logic                cfg_busy_in,
  input  wire logic                cfg_done_in,
  output var  fbcl_flash_s         flash,
  output logic                     flash_ctl_oe_n,
  input  wire logic [FLASH_DW-1:0] flash_dq_in,
  output var  logic [FLASH_DW-1:0] flash_dq_out,
  output logic                     flash_dq_oe_n,
  input  wire logic                prog_wr_req,
  input  wire logic [FLASH_AW-1:0] prog_wr_addr,
  input  wire logic [FLASH_DW-1:0] prog_wr_data,
  output logic                     prog_wr_ready,
  output var  logic                prog_wr_ack
);

  // Elaboration guards: the counters cannot serve other values
  if (CFG_CLK_HALF < 1 || CFG_CLK_HALF > 255)
  begin : g_bad_half
    $error("CFG_CLK_HALF out of range");
  end
  if (SET_WORDS < 1 || SET_WORDS > (1 << SET_AW))
  begin : g_bad_words
    $error("SET_WORDS does not fit a set region");
  end

  // ==========================================================
  // Pin synchronisers
  localparam int PIN_W = 17;
  logic [PIN_W-1:0]    pin_meta;
  logic [PIN_W-1:0]    pin_sync;
  logic [FLASH_DW-1:0] dq_meta;
  logic [FLASH_DW-1:0] dq_sync;
  logic                flash_en_s;
  logic                reset_s;
  logic [2:0]          pin_set_s;
  logic                jtag_ovr_s;
  logic [2:0]          jtag_set_s;
  logic                par_s;
  logic [3:0]          cs_en_s;
  logic                init_s;
  logic                busy_s;
  logic                done_s;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
      dq_meta  <= '0;
      dq_sync  <= '0;
    end
    else if (clk_en)
    begin
      pin_meta <= {flash_ctrl_enable, sys_reset_pulse, design_set_select,
                   jtag_set_override, jtag_set_value, parallel_mode,
                   target_cs_enable, cfg_init_in, cfg_busy_in,
                   cfg_done_in};
      pin_sync <= pin_meta;
      dq_meta  <= flash_dq_in;
      dq_sync  <= dq_meta;
    end
  end

  assign {flash_en_s, reset_s, pin_set_s, jtag_ovr_s, jtag_set_s, par_s,
          cs_en_s, init_s, busy_s, done_s} = pin_sync;

  // ==========================================================
  // Start requests: power-up and reset pulse rising edge
  logic reset_d;
  logic start_pend;
  logic start;
  fbcl_cfg_state_e cfg_st;

  logic [1:0] sync_warm;

  // Power-up start waits until the pin synchronisers hold real values
  assign start = start_pend && cfg_st == CF_IDLE && sync_warm[1];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sync_warm <= 2'h0;
    else if (clk_en && !sync_warm[1])
      sync_warm <= sync_warm + 2'h1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reset_d    <= 1'b0;
      start_pend <= 1'b1;
    end
    else if (clk_en)
    begin
      reset_d <= reset_s;
      // A pulse during a load is held until the sequencer is idle, and set wins over the clear
      if (reset_s && !reset_d)
        start_pend <= 1'b1;
      else if (start)
        start_pend <= 1'b0;
    end
  end

  // ==========================================================
  // Configuration clock divider
  logic [7:0] div_cnt;
  logic       cfg_clk_run;
  logic       tick;
  logic       cfg_clk_rise;
  logic       cfg_clk_fall;
  logic       data_valid;
  logic       par_mode;

  assign cfg_clk_run  = cfg_st == CF_LOAD || cfg_st == CF_FLUSH;
  // Clock parks low with no byte ready, except in flush: targets take a bit at every rise
  assign tick         = cfg_clk_run && div_cnt == 8'(CFG_CLK_HALF - 1) &&
                        (cfg_clock_pin || data_valid || cfg_st == CF_FLUSH);
  assign cfg_clk_rise = tick && !cfg_clock_pin;
  assign cfg_clk_fall = tick && cfg_clock_pin;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_cnt       <= 8'h00;
      cfg_clock_pin <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!cfg_clk_run)
      begin
        div_cnt       <= 8'h00;
        cfg_clock_pin <= 1'b0;
      end
      else if (tick)
      begin
        // Toggle at most every system clock: half rate or slower
        div_cnt       <= 8'h00;
        cfg_clock_pin <= !cfg_clock_pin;
      end
      else if (div_cnt != 8'(CFG_CLK_HALF - 1))
        div_cnt <= div_cnt + 8'h01;
    end
  end

  // ==========================================================
  // Word buffer between flash reads and the byte shifter
  logic [FLASH_DW-1:0] word_buf;
  logic                buf_valid;
  logic                byte_hi;
  logic                load_byte;
  logic                take_word;
  logic                buf_fill;
  logic [SET_AW:0]     words_left;

  // New byte only while the clock is low or falling and not rising, never when busy in parallel mode
  assign load_byte = cfg_st == CF_LOAD && !data_valid && buf_valid &&
                     !cfg_clk_rise && (cfg_clk_fall || !cfg_clock_pin) &&
                     !(par_mode && busy_s);
  assign take_word = load_byte && byte_hi;

  // ==========================================================
  // Flash engine
  fbcl_flash_state_e   fl_st;
  logic [7:0]          fl_cnt;
  logic [SET_AW-1:0]   rd_ptr;
  logic [2:0]          set_sel;
  logic                rd_want;

  // Next read starts once the last byte of the current word is loaded
  assign rd_want = cfg_st == CF_LOAD && !buf_valid && words_left != '0;
  assign buf_fill = fl_st == FL_READ && flash_en_s &&
                    fl_cnt == 8'(FLASH_ACC_CYC + 1);
  assign prog_wr_ready = fl_st == FL_IDLE && flash_en_s &&
                         !cfg_clk_run && !start_pend;
  assign flash_ctl_oe_n = !flash_en_s;
  assign flash_dq_oe_n  = !(flash_en_s && fl_st == FL_WRITE);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fl_st        <= FL_IDLE;
      fl_cnt       <= 8'h00;
      flash        <= '{addr: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      flash_dq_out <= '0;
      prog_wr_ack  <= 1'b0;
    end
    else if (clk_en)
    begin
      prog_wr_ack <= 1'b0;
      unique case (fl_st)
        FL_IDLE:
        begin
          fl_cnt <= 8'h00;
          if (flash_en_s && rd_want)
          begin
            fl_st        <= FL_READ;
            flash.addr   <= {set_sel, rd_ptr};
            flash.ce_n   <= 1'b0;
            flash.oe_n   <= 1'b0;
          end
          else if (prog_wr_req && prog_wr_ready)
          begin
            fl_st        <= FL_WRITE;
            flash.addr   <= prog_wr_addr;
            flash_dq_out <= prog_wr_data;
            flash.ce_n   <= 1'b0;
            flash.we_n   <= 1'b0;
          end
        end
        FL_READ:
        begin
          fl_cnt <= fl_cnt + 8'h01;
          // Two extra cycles cover the data synchroniser
          if (!flash_en_s || buf_fill || cfg_st != CF_LOAD)
          begin
            fl_st      <= FL_IDLE;
            flash.ce_n <= 1'b1;
            flash.oe_n <= 1'b1;
          end
        end
        FL_WRITE:
        begin
          fl_cnt <= fl_cnt + 8'h01;
          if (fl_cnt == 8'(FLASH_WE_CYC - 1))
          begin
            fl_st       <= FL_IDLE;
            flash.ce_n  <= 1'b1;
            flash.we_n  <= 1'b1;
            prog_wr_ack <= 1'b1;
          end
        end
        default:
          fl_st <= FL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      word_buf   <= '0;
      buf_valid  <= 1'b0;
      byte_hi    <= 1'b0;
      rd_ptr     <= '0;
      words_left <= '0;
    end
    else if (clk_en)
    begin
      if (cfg_st == CF_INIT)
      begin
        buf_valid  <= 1'b0;
        byte_hi    <= 1'b0;
        rd_ptr     <= '0;
        words_left <= (SET_AW + 1)'(SET_WORDS);
      end
      else if (buf_fill)
      begin
        word_buf   <= dq_sync;
        buf_valid  <= 1'b1;
        rd_ptr     <= rd_ptr + SET_AW'(1);
        words_left <= words_left - (SET_AW + 1)'(1);
      end
      else if (load_byte)
      begin
        byte_hi <= !byte_hi;
        if (take_word)
          buf_valid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Configuration sequencer
  logic [7:0] st_cnt;
  logic       flush_end;

  assign flush_end = cfg_st == CF_FLUSH && cfg_clk_rise &&
                     st_cnt == 8'(DONE_EXTRA_CLKS - 1);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_st               <= CF_IDLE;
      st_cnt               <= 8'h00;
      set_sel              <= 3'h0;
      par_mode             <= 1'b0;
      target_program_out_n <= 1'b1;
      status               <= '0;
    end
    else if (clk_en)
    begin
      status.flash_off <= !flash_en_s;
      status.busy      <= cfg_st != CF_IDLE;
      unique case (cfg_st)
        CF_IDLE:
        begin
          st_cnt <= 8'h00;
          if (start)
          begin
            set_sel  <= jtag_ovr_s ? jtag_set_s : pin_set_s;
            par_mode <= par_s;
            status.done  <= 1'b0;
            status.error <= 1'b0;
            target_program_out_n <= 1'b0;
            cfg_st <= CF_PROG;
          end
        end
        CF_PROG:
        begin
          st_cnt <= st_cnt + 8'h01;
          if (st_cnt == 8'(PROG_LOW_CYC - 1))
          begin
            target_program_out_n <= 1'b1;
            cfg_st <= CF_INIT;
          end
        end
        CF_INIT:
        begin
          st_cnt <= 8'h00;
          if (init_s)
            cfg_st <= CF_LOAD;
        end
        CF_LOAD, CF_FLUSH:
        begin
          if (done_s)
          begin
            status.done <= 1'b1;
            cfg_st      <= CF_IDLE;
          end
          else if (!init_s || flush_end)
          begin
            status.error <= 1'b1;
            cfg_st       <= CF_IDLE;
          end
          else if (cfg_st == CF_LOAD && words_left == '0 &&
                   !buf_valid && !data_valid)
            cfg_st <= CF_FLUSH;
          else if (cfg_st == CF_FLUSH && cfg_clk_rise)
            st_cnt <= st_cnt + 8'h01;
        end
        default:
          cfg_st <= CF_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Target data path
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_data   <= CFG_DATA_IDLE;
      data_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!cfg_clk_run)
        data_valid <= 1'b0;
      else if (cfg_clk_rise && data_valid && !(par_mode && busy_s))
        data_valid <= 1'b0;
      else if (load_byte)
      begin
        // Same byte serves D7..D0 or one bit per serial chain
        cfg_data   <= byte_hi ? word_buf[15:8] : word_buf[7:0];
        data_valid <= 1'b1;
      end
    end
  end

  // Selects and direction are asserted only in parallel mode while in load or flush
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_mode     <= MODE_SERIAL;
      read_write_n <= 1'b1;
      cfg_cs_n     <= CS_N_IDLE;
    end
    else if (clk_en)
    begin
      cfg_mode <= par_mode ? MODE_PARALLEL : MODE_SERIAL;
      if (par_mode && cfg_clk_run)
      begin
        read_write_n <= 1'b0;
        cfg_cs_n     <= ~cs_en_s;
      end
      else
      begin
        read_write_n <= 1'b1;
        cfg_cs_n     <= CS_N_IDLE;
      end
    end
  end

endmodule : fbcl_loader
`default_nettype wire

// >>> verification/fbcl_loader_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker
module fbcl_loader_asserts
  import fbcl_pkg::*;
#(
  parameter int CFG_CLK_HALF = 1
)(
  input wire logic         clk,
  input wire logic         resetn,
  input wire logic         flash_ctrl_enable,
  input wire logic [3:0]   target_cs_enable,
  input wire fbcl_status_s status,
  input wire logic [2:0]   cfg_mode,
  input wire logic         target_program_out_n,
  input wire logic         cfg_clock_pin,
  input wire logic [7:0]   cfg_data,
  input wire logic         read_write_n,
  input wire logic [3:0]   cfg_cs_n,
  input wire logic         cfg_init_in,
  input wire logic         cfg_busy_in,
  input wire logic         cfg_done_in,
  input wire fbcl_flash_s  flash,
  input wire logic         flash_ctl_oe_n,
  input wire logic         flash_dq_oe_n,
  input wire logic         prog_wr_req,
  input wire logic         prog_wr_ready,
  input wire logic         prog_wr_ack
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // Counts the program pulse so its full length can be judged
  logic [7:0] prog_cnt;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      prog_cnt <= 8'h00;
    else if (target_program_out_n)
      prog_cnt <= 8'h00;
    else
      prog_cnt <= prog_cnt + 8'h01;

  chk_flash_release:
    assert property (!flash_ctrl_enable [*4] |-> flash_ctl_oe_n)
    else $error("flash controls not released");
  chk_prog_length:
    assert property ($rose(target_program_out_n) |->
      prog_cnt == PROG_LOW_CYC)
    else $error("program pulse length wrong");
  chk_cfg_clock_pin_half:
    assert property ($rose(cfg_clock_pin) |->
      ##CFG_CLK_HALF !cfg_clock_pin)
    else $error("configuration clock too fast");
  chk_data_edge:
    assert property ($changed(cfg_data) |-> !cfg_clock_pin)
    else $error("data changed with clock high");
  chk_rw_mode:
    assert property (!read_write_n |-> cfg_mode == MODE_PARALLEL)
    else $error("write strobe outside parallel mode");
  chk_cs_follow:
    assert property (cfg_cs_n ==
      (read_write_n ? CS_N_IDLE : ~target_cs_enable))
    else $error("chip selects wrong");
  chk_busy_hold:
    assert property ((!read_write_n && cfg_busy_in) [*5] |->
      $stable(cfg_data))
    else $error("data changed while target busy");
  chk_done_seen:
    assert property (cfg_done_in [*3] ##0 status.busy |->
      ##[1:6] status.done)
    else $error("done not reported");
  chk_init_error:
    assert property ((!read_write_n && !cfg_init_in) [*3] |->
      ##[1:6] status.error)
    else $error("init fall not reported");
  chk_write_cycle:
    assert property (prog_wr_req && prog_wr_ready |=>
      !flash.we_n && !flash.ce_n && !flash_dq_oe_n ##[6:7] prog_wr_ack)
    else $error("flash write cycle wrong");
endmodule : fbcl_loader_asserts
`default_nettype wire

// >>> verification/fbcl_target_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Flash and target stand-in
module fbcl_target_model
  import fbcl_pkg::*;
#(
  parameter int DONE_AT = 6
)(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        target_program_out_n,
  input  wire logic        cfg_clock_pin,
  input  wire logic [7:0]  cfg_data,
  input  wire logic [3:0]  cfg_cs_n,
  input  wire logic        parallel_mode,
  input  wire fbcl_flash_s flash,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_dq_oe_n,
  input  wire logic        stall,
  input  wire logic        fail,
  output logic             cfg_init_in,
  output logic             cfg_busy_in,
  output logic             cfg_done_in,
  output logic [15:0]      flash_dq_in,
  output logic [23:0]      seen
);
  logic [7:0]  n_bytes;
  logic        cfg_clk_q;
  logic [15:0] dq_last;
  wire logic   rd;

  // Words carry set and index; a released bus shows no stale value
  assign rd = !flash.ce_n && !flash.oe_n;
  assign flash_dq_in = !flash_dq_oe_n ? flash_dq_out :
    rd ? {flash.addr[21:19], 5'h00, flash.addr[7:0]} : ~dq_last;
  assign cfg_busy_in = stall;

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      {n_bytes, cfg_clk_q, dq_last, seen} <= '0;
      {cfg_init_in, cfg_done_in} <= 2'h0;
    end
    else
    begin
      cfg_clk_q <= cfg_clock_pin;
      dq_last <= flash_dq_in;
      cfg_init_in <= target_program_out_n && !fail;
      cfg_done_in <= target_program_out_n && n_bytes >= DONE_AT;
      if (!target_program_out_n)
        n_bytes <= 8'h00;
      else if (cfg_clock_pin && !cfg_clk_q && !stall &&
               (!parallel_mode || !cfg_cs_n[0]))
      begin
        if (n_bytes < 8'h03)
          seen[n_bytes*8 +: 8] <= cfg_data;
        n_bytes <= n_bytes + 8'h01;
      end
    end
endmodule : fbcl_target_model
`default_nettype wire

// >>> verification/test_fbcl_loader.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Top of the bench
module test_fbcl_loader
  import fbcl_pkg::*;
;
  logic         clk, resetn, flash_ctrl_enable, sys_reset_pulse;
  logic         jtag_set_override, parallel_mode, stall, fail;
  logic         target_program_out_n, cfg_clock_pin, read_write_n;
  logic         cfg_init_in, cfg_busy_in, cfg_done_in, prog_wr_req;
  logic         flash_ctl_oe_n, flash_dq_oe_n, prog_wr_ready, prog_wr_ack;
  logic [2:0]   design_set_select, jtag_set_value, cfg_mode;
  logic [3:0]   target_cs_enable, cfg_cs_n;
  logic [7:0]   cfg_data;
  logic [15:0]  flash_dq_in, flash_dq_out, prog_wr_data;
  logic [21:0]  prog_wr_addr;
  logic [23:0]  seen;
  fbcl_status_s status;
  fbcl_flash_s  flash;
  int           n_errors, n_tests;

  // Short sets keep each load near a hundred cycles
  fbcl_loader #(.CFG_CLK_HALF(1), .SET_WORDS(8)) DUT (.clk, .resetn,
    .clk_en(1'b1), .flash_ctrl_enable, .sys_reset_pulse,
    .design_set_select, .jtag_set_override, .jtag_set_value,
    .parallel_mode, .target_cs_enable, .status, .cfg_mode,
    .target_program_out_n, .cfg_clock_pin, .cfg_data, .read_write_n,
    .cfg_cs_n, .cfg_init_in, .cfg_busy_in, .cfg_done_in, .flash,
    .flash_ctl_oe_n, .flash_dq_in, .flash_dq_out, .flash_dq_oe_n,
    .prog_wr_req, .prog_wr_addr, .prog_wr_data, .prog_wr_ready,
    .prog_wr_ack);
  fbcl_target_model u_model (.clk, .resetn, .target_program_out_n,
    .cfg_clock_pin, .cfg_data, .cfg_cs_n, .parallel_mode, .flash,
    .flash_dq_out, .flash_dq_oe_n, .stall, .fail, .cfg_init_in,
    .cfg_busy_in, .cfg_done_in, .flash_dq_in, .seen);

  always #4 clk = ~clk;

  task automatic check(string what, logic [23:0] got, logic [23:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // Waits out one load, optionally stalling or failing the target
  task automatic wait_load(logic [2:0] set, logic par, logic stl,
                           logic bad);
    int k;
    for (k = 0; k < 100 && !status.busy; k++) @(negedge clk);
    check("busy", status.busy, 1'b1);
    for (k = 0; k < 500 && par && read_write_n; k++) @(negedge clk);
    check("rw_n", read_write_n, !par);
    check("cs_n", cfg_cs_n, par ? 4'ha : 4'hf);
    @(posedge clk);
    stall <= stl;
    fail <= bad;
    repeat (20) @(posedge clk);
    stall <= 1'b0;
    for (k = 0; k < 3000 && status.busy; k++) @(negedge clk);
    check("error", status.error, bad);
    check("done", status.done, !bad);
    check("mode", cfg_mode, par ? MODE_PARALLEL : MODE_SERIAL);
    if (!bad)
      check("bytes", seen, {8'h01, set, 5'h00, 8'h00});
    @(posedge clk) fail <= 1'b0;
  endtask : wait_load

  task automatic reload(logic [2:0] sel, logic [2:0] set, logic par,
                        logic stl, logic bad);
    @(posedge clk);
    design_set_select <= sel;
    parallel_mode <= par;
    sys_reset_pulse <= 1'b1;
    repeat (3) @(posedge clk);
    sys_reset_pulse <= 1'b0;
    wait_load(set, par, stl, bad);
  endtask : reload

  task automatic flash_off_test;
    @(posedge clk) flash_ctrl_enable <= 1'b0;
    repeat (5) @(negedge clk);
    check("released", {flash_ctl_oe_n, status.flash_off}, 2'h3);
    @(posedge clk) flash_ctrl_enable <= 1'b1;
    repeat (5) @(negedge clk);
    check("driven", {flash_ctl_oe_n, status.flash_off}, 2'h0);
  endtask : flash_off_test

  task automatic write_test;
    int k;
    @(posedge clk);
    prog_wr_req <= 1'b1;
    prog_wr_addr <= 22'h123456;
    prog_wr_data <= 16'hbeef;
    @(negedge clk);
    for (k = 0; k < 200 && !prog_wr_ready; k++) @(negedge clk);
    @(posedge clk) prog_wr_req <= 1'b0;
    @(negedge clk);
    check("strobes", {flash.we_n, flash.ce_n, flash_dq_oe_n}, 3'h0);
    check("wr_addr", flash.addr, 22'h123456);
    check("wr_data", flash_dq_in, 16'hbeef);
    for (k = 0; k < 20 && !prog_wr_ack; k++) @(negedge clk);
    check("ack", prog_wr_ack, 1'b1);
  endtask : write_test

  initial
  begin
    {clk, resetn, sys_reset_pulse, jtag_set_override, parallel_mode} = '0;
    {stall, fail, prog_wr_req, prog_wr_addr, prog_wr_data} = '0;
    {jtag_set_value, n_errors, n_tests} = '0;
    flash_ctrl_enable = 1'b1;
    design_set_select = 3'h3;
    target_cs_enable = 4'h5;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    wait_load(3'h3, 1'b0, 1'b0, 1'b0);
    reload(3'h1, 3'h1, 1'b1, 1'b0, 1'b1);
    for (int s = 0; s < 8; s++)
      reload(s[2:0], s[2:0], s[0], 1'b0, 1'b0);
    @(posedge clk);
    jtag_set_override <= 1'b1;
    jtag_set_value <= 3'h5;
    reload(3'h2, 3'h5, 1'b1, 1'b0, 1'b0);
    jtag_set_override <= 1'b0;
    reload(3'h6, 3'h6, 1'b1, 1'b1, 1'b0);
    flash_off_test();
    write_test();
    end_of_test();
  end

  initial
  begin
    #400000;
    n_errors++;
    end_of_test();
  end
endmodule : test_fbcl_loader

bind fbcl_loader fbcl_loader_asserts #(.CFG_CLK_HALF(CFG_CLK_HALF)) u_chk (
  .clk, .resetn, .flash_ctrl_enable, .target_cs_enable, .status,
  .cfg_mode, .target_program_out_n, .cfg_clock_pin, .cfg_data,
  .read_write_n, .cfg_cs_n, .cfg_init_in, .cfg_busy_in, .cfg_done_in,
  .flash, .flash_ctl_oe_n, .flash_dq_oe_n, .prog_wr_req, .prog_wr_ready,
  .prog_wr_ack);
`default_nettype wire
